// file: ptg_regs.vh
`ifndef PTG_REGS_VH
`define PTG_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define PTG_ADDR_PERIOD 8'h1d
`define PTG_ADDR_TIMING 8'h1e
`define PTG_ADDR_SPLIT 8'h20
`define PTG_ADDR_PRIMARY 8'h21
// ****************************************
// field positions
// ****************************************
`define PTG_PERIOD_MSB 15
`define PTG_PERIOD_LSB 0
`define PTG_ENGINE_EN_BIT 8
`define PTG_AVG_MSB 3
`define PTG_AVG_LSB 0
`define PTG_SPLIT_SEL_BIT 15
`define PTG_CAP_MSB 5
`define PTG_CAP_LSB 3
`define PTG_RES_MSB 2
`define PTG_RES_LSB 0
`define PTG_PULSE_EN_BIT 8
// ****************************************
// reset values
// ****************************************
`define PTG_RST_16 16'h0000
`define PTG_RST_4 4'h0
`define PTG_RST_3 3'h0
`define PTG_RST_24 24'h00_0000
// ****************************************
// analog codes: resistor in kilohm, capacitor in tenths of pF
// ****************************************
`define PTG_RES_K0 12'h1f4
`define PTG_RES_K1 12'h0fa
`define PTG_RES_K2 12'h064
`define PTG_RES_K3 12'h032
`define PTG_RES_K4 12'h019
`define PTG_RES_K5 12'h00a
`define PTG_RES_K6 12'h3e8
`define PTG_RES_K7 12'h7d0
`define PTG_CAP_T0 8'h32
`define PTG_CAP_T1 8'h19
`define PTG_CAP_T2 8'h64
`define PTG_CAP_T3 8'h4b
`define PTG_CAP_T4 8'hc8
`define PTG_CAP_T5 8'haf
`define PTG_CAP_T6 8'hfa
`define PTG_CAP_T7 8'he1
`endif

// file: ptg_period_cnt.v
`timescale 1ns/1ps
`default_nettype none
`include "ptg_regs.vh"
module ptg_period_cnt (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire enable_i,
  input wire [15:0] period_count_value_i,
  output wire [15:0] count_o,
  output wire wrap_o
);
  reg [15:0] count_r;
  reg [15:0] count_nxt;
  assign count_o = count_r;
  assign wrap_o = enable_i && (count_r >= period_count_value_i);
  always @* begin
    count_nxt = count_r;
    if (!enable_i) begin
      count_nxt = `PTG_RST_16;
    end else if (count_r >= period_count_value_i) begin
      // >= so a period lowered below the count still wraps at once
      count_nxt = `PTG_RST_16;
    end else begin
      count_nxt = count_r + 16'h0001;
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      count_r <= `PTG_RST_16;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

// file: ptg_config.v
`timescale 1ns/1ps
`default_nettype none
`include "ptg_regs.vh"
module ptg_config (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire [23:0] wdata_i,
  output reg [23:0] rdata_o,
  input wire conv_ready_i,
  input wire [15:0] custom_pulse_start_i,
  input wire [15:0] custom_pulse_end_i,
  output reg conv_ready_o,
  output wire timing_engine_enable_o,
  output wire [15:0] period_count_o,
  output wire period_wrap_o,
  output wire [4:0] average_samples_o,
  output wire split_gain_select_o,
  output wire [2:0] cap1_code_o,
  output wire [2:0] cap2_code_o,
  output wire [2:0] res1_code_o,
  output wire [2:0] res2_code_o,
  output reg [11:0] res1_kohm_o,
  output reg [11:0] res2_kohm_o,
  output reg [7:0] cap1_tenth_pf_o,
  output reg [7:0] cap2_tenth_pf_o
);
  // ****************************************
  // register file
  // ****************************************
  reg [15:0] period_count_value_r;
  reg timing_engine_enable_r;
  reg [3:0] average_count_r;
  reg split_gain_select_r;
  reg [2:0] second_feedback_cap_r;
  reg [2:0] second_feedback_res_r;
  reg [2:0] feedback_cap_code_r;
  reg [2:0] feedback_res_code_r;
  reg custom_pulse_enable_r;
  reg [15:0] period_count_value_nxt;
  reg timing_engine_enable_nxt;
  reg [3:0] average_count_nxt;
  reg split_gain_select_nxt;
  reg [2:0] second_feedback_cap_nxt;
  reg [2:0] second_feedback_res_nxt;
  reg [2:0] feedback_cap_code_nxt;
  reg [2:0] feedback_res_code_nxt;
  reg custom_pulse_enable_nxt;
  reg conv_ready_nxt;
  reg pulse_active_r;
  reg pulse_active_nxt;
  reg [23:0] rdata_nxt;
  wire [15:0] cnt;

  function [11:0] res_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0: res_decode = `PTG_RES_K0;
        3'h1: res_decode = `PTG_RES_K1;
        3'h2: res_decode = `PTG_RES_K2;
        3'h3: res_decode = `PTG_RES_K3;
        3'h4: res_decode = `PTG_RES_K4;
        3'h5: res_decode = `PTG_RES_K5;
        3'h6: res_decode = `PTG_RES_K6;
        default: res_decode = `PTG_RES_K7;
      endcase
    end
  endfunction

  function [7:0] cap_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0: cap_decode = `PTG_CAP_T0;
        3'h1: cap_decode = `PTG_CAP_T1;
        3'h2: cap_decode = `PTG_CAP_T2;
        3'h3: cap_decode = `PTG_CAP_T3;
        3'h4: cap_decode = `PTG_CAP_T4;
        3'h5: cap_decode = `PTG_CAP_T5;
        3'h6: cap_decode = `PTG_CAP_T6;
        default: cap_decode = `PTG_CAP_T7;
      endcase
    end
  endfunction

  function [2:0] gain_pick;
    input split;
    input [2:0] second_code;
    input [2:0] primary_code;
    begin
      if (split) begin
        gain_pick = second_code;
      end else begin
        gain_pick = primary_code;
      end
    end
  endfunction

  // ****************************************
  // register write
  // ****************************************
  always @* begin
    period_count_value_nxt = period_count_value_r;
    timing_engine_enable_nxt = timing_engine_enable_r;
    average_count_nxt = average_count_r;
    split_gain_select_nxt = split_gain_select_r;
    second_feedback_cap_nxt = second_feedback_cap_r;
    second_feedback_res_nxt = second_feedback_res_r;
    feedback_cap_code_nxt = feedback_cap_code_r;
    feedback_res_code_nxt = feedback_res_code_r;
    custom_pulse_enable_nxt = custom_pulse_enable_r;
    if (wr_en_i) begin
      // must-write-0 bits are simply dropped
      case (addr_i)
        `PTG_ADDR_PERIOD: begin
          period_count_value_nxt = wdata_i[`PTG_PERIOD_MSB:`PTG_PERIOD_LSB];
        end
        `PTG_ADDR_TIMING: begin
          timing_engine_enable_nxt = wdata_i[`PTG_ENGINE_EN_BIT];
          average_count_nxt = wdata_i[`PTG_AVG_MSB:`PTG_AVG_LSB];
        end
        `PTG_ADDR_SPLIT: begin
          split_gain_select_nxt = wdata_i[`PTG_SPLIT_SEL_BIT];
          second_feedback_cap_nxt = wdata_i[`PTG_CAP_MSB:`PTG_CAP_LSB];
          second_feedback_res_nxt = wdata_i[`PTG_RES_MSB:`PTG_RES_LSB];
        end
        `PTG_ADDR_PRIMARY: begin
          custom_pulse_enable_nxt = wdata_i[`PTG_PULSE_EN_BIT];
          feedback_cap_code_nxt = wdata_i[`PTG_CAP_MSB:`PTG_CAP_LSB];
          feedback_res_code_nxt = wdata_i[`PTG_RES_MSB:`PTG_RES_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      period_count_value_r <= `PTG_RST_16;
      timing_engine_enable_r <= 1'b0;
      average_count_r <= `PTG_RST_4;
      split_gain_select_r <= 1'b0;
      second_feedback_cap_r <= `PTG_RST_3;
      second_feedback_res_r <= `PTG_RST_3;
      feedback_cap_code_r <= `PTG_RST_3;
      feedback_res_code_r <= `PTG_RST_3;
      custom_pulse_enable_r <= 1'b0;
    end else begin
      period_count_value_r <= period_count_value_nxt;
      timing_engine_enable_r <= timing_engine_enable_nxt;
      average_count_r <= average_count_nxt;
      split_gain_select_r <= split_gain_select_nxt;
      second_feedback_cap_r <= second_feedback_cap_nxt;
      second_feedback_res_r <= second_feedback_res_nxt;
      feedback_cap_code_r <= feedback_cap_code_nxt;
      feedback_res_code_r <= feedback_res_code_nxt;
      custom_pulse_enable_r <= custom_pulse_enable_nxt;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @* begin
    rdata_nxt = `PTG_RST_24;
    case (addr_i)
      `PTG_ADDR_PERIOD: begin
        rdata_nxt[`PTG_PERIOD_MSB:`PTG_PERIOD_LSB] = period_count_value_r;
      end
      `PTG_ADDR_TIMING: begin
        rdata_nxt[`PTG_ENGINE_EN_BIT] = timing_engine_enable_r;
        rdata_nxt[`PTG_AVG_MSB:`PTG_AVG_LSB] = average_count_r;
      end
      `PTG_ADDR_SPLIT: begin
        rdata_nxt[`PTG_SPLIT_SEL_BIT] = split_gain_select_r;
        rdata_nxt[`PTG_CAP_MSB:`PTG_CAP_LSB] = second_feedback_cap_r;
        rdata_nxt[`PTG_RES_MSB:`PTG_RES_LSB] = second_feedback_res_r;
      end
      `PTG_ADDR_PRIMARY: begin
        // pulse enable is write only, reads zero
        rdata_nxt[`PTG_CAP_MSB:`PTG_CAP_LSB] = feedback_cap_code_r;
        rdata_nxt[`PTG_RES_MSB:`PTG_RES_LSB] = feedback_res_code_r;
      end
      default: begin
        rdata_nxt = `PTG_RST_24;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_o <= `PTG_RST_24;
    end else if (rd_en_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  // ****************************************
  // timing engine
  // ****************************************
  ptg_period_cnt u_period_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .enable_i(timing_engine_enable_r),
    .period_count_value_i(period_count_value_r),
    .count_o(cnt),
    .wrap_o(period_wrap_o)
  );
  assign period_count_o = cnt;
  assign timing_engine_enable_o = timing_engine_enable_r;
  assign average_samples_o = {1'b0, average_count_r} + 5'h01;

  always @* begin
    pulse_active_nxt = pulse_active_r;
    if (!timing_engine_enable_r) begin
      pulse_active_nxt = 1'b0;
    end else if (cnt == custom_pulse_start_i) begin
      pulse_active_nxt = 1'b1;
    end else if (cnt == custom_pulse_end_i) begin
      pulse_active_nxt = 1'b0;
    end
  end

  // ****************************************
  // conversion-ready pin
  // ****************************************
  always @* begin
    conv_ready_nxt = conv_ready_i;
    if (custom_pulse_enable_r) begin
      conv_ready_nxt = pulse_active_nxt;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pulse_active_r <= 1'b0;
      conv_ready_o <= 1'b0;
    end else begin
      pulse_active_r <= pulse_active_nxt;
      // registered mux keeps the pin glitch free
      conv_ready_o <= conv_ready_nxt;
    end
  end

  // ****************************************
  // gain routing
  // ****************************************
  assign split_gain_select_o = split_gain_select_r;
  assign cap1_code_o = feedback_cap_code_r;
  assign res1_code_o = feedback_res_code_r;
  assign cap2_code_o = gain_pick(split_gain_select_r, second_feedback_cap_r, feedback_cap_code_r);
  assign res2_code_o = gain_pick(split_gain_select_r, second_feedback_res_r, feedback_res_code_r);

  // ****************************************
  // decoded gain values
  // ****************************************
  // registered, so a code change reaches the analog side one clock later
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      res1_kohm_o <= `PTG_RES_K0;
    end else begin
      res1_kohm_o <= res_decode(res1_code_o);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      res2_kohm_o <= `PTG_RES_K0;
    end else begin
      res2_kohm_o <= res_decode(res2_code_o);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cap1_tenth_pf_o <= `PTG_CAP_T0;
    end else begin
      cap1_tenth_pf_o <= cap_decode(cap1_code_o);
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cap2_tenth_pf_o <= `PTG_CAP_T0;
    end else begin
      cap2_tenth_pf_o <= cap_decode(cap2_code_o);
    end
  end
endmodule
`default_nettype wire

// file: ptg_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// config port checks
// ****
module ptg_config_properties (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic [23:0] rdata_o,
  input wire logic timing_engine_enable_o,
  input wire logic [15:0] period_count_o,
  input wire logic period_wrap_o,
  input wire logic [4:0] average_samples_o,
  input wire logic split_gain_select_o,
  input wire logic [2:0] cap1_code_o,
  input wire logic [2:0] cap2_code_o,
  input wire logic [2:0] res1_code_o,
  input wire logic [2:0] res2_code_o,
  input wire logic [11:0] res1_kohm_o
);
  localparam logic [11:0] RK [8] = '{12'h1f4, 12'h0fa, 12'h064, 12'h032, 12'h019, 12'h00a, 12'h3e8, 12'h7d0};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  chk_avg_plus_one: assert property (wr_en_i && addr_i == 8'h1e |=> average_samples_o == $past(wdata_i[3:0]) + 5'h1)
    else $error("average count wrong");
  chk_engine_bit: assert property (wr_en_i && addr_i == 8'h1e |=> timing_engine_enable_o == $past(wdata_i[8]))
    else $error("engine enable wrong");
  chk_split_bit: assert property (wr_en_i && addr_i == 8'h20 |=> split_gain_select_o == $past(wdata_i[15]))
    else $error("split select wrong");
  chk_hold_zero: assert property (!timing_engine_enable_o |=> period_count_o == 16'h0000)
    else $error("counter not held");
  chk_count_step: assert property (timing_engine_enable_o && !period_wrap_o |=> period_count_o == $past(period_count_o) + 16'h0001)
    else $error("counter step wrong");
  chk_count_wrap: assert property (period_wrap_o |=> period_count_o == 16'h0000)
    else $error("counter wrap wrong");
  chk_single_gain: assert property (!split_gain_select_o |-> cap2_code_o == cap1_code_o && res2_code_o == res1_code_o)
    else $error("shared gain wrong");
  chk_res_decode: assert property (1'b1 |=> res1_kohm_o == RK[$past(res1_code_o)])
    else $error("resistor decode wrong");
  chk_unmapped_read: assert property (rd_en_i && !(addr_i inside {8'h1d, 8'h1e, 8'h20, 8'h21}) |=> rdata_o == 24'h00_0000)
    else $error("unmapped read not zero");
  cover property (period_wrap_o);
  cover property (split_gain_select_o && cap2_code_o != cap1_code_o);
  cover property (rd_en_i && addr_i == 8'h21);
endmodule
bind ptg_config ptg_config_properties chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .period_wrap_o(period_wrap_o),
  .timing_engine_enable_o(timing_engine_enable_o), .period_count_o(period_count_o), .res1_kohm_o(res1_kohm_o),
  .average_samples_o(average_samples_o), .split_gain_select_o(split_gain_select_o), .cap1_code_o(cap1_code_o),
  .cap2_code_o(cap2_code_o), .res1_code_o(res1_code_o), .res2_code_o(res2_code_o));
`default_nettype wire

// file: ptg_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench and model
// ****
module ptg_config_tb;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, cr_i = 1'b0, s;
  logic [7:0] addr_i = 8'h00;
  logic [23:0] wdata_i = 24'h00_0000, lf = 24'd92377;
  logic [15:0] ps_i = 16'h0002, pe_i = 16'h0004;
  logic [5:0] a, b;
  wire [23:0] rd_o;
  wire cr_o, en_o, wrap_o, sel_o;
  wire [15:0] cnt_o;
  wire [4:0] avg_o;
  wire [2:0] c1, c2, r1, r2;
  wire [11:0] k1, k2;
  wire [7:0] t1, t2;
  int n_fail = 0, comparisons = 0, cyc = 0, i, m, n, mc;
  int kt[8] = '{500, 250, 100, 50, 25, 10, 1000, 2000};
  int ct[8] = '{50, 25, 100, 75, 200, 175, 250, 225};
  logic [7:0] ad[4] = '{8'h1d, 8'h1e, 8'h20, 8'h21};
  logic [23:0] mk[4] = '{24'h00_ffff, 24'h00_010f, 24'h00_803f, 24'h00_003f};
  ptg_config dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rd_o), .conv_ready_i(cr_i), .custom_pulse_start_i(ps_i),
    .custom_pulse_end_i(pe_i), .conv_ready_o(cr_o), .timing_engine_enable_o(en_o), .period_count_o(cnt_o),
    .period_wrap_o(wrap_o), .average_samples_o(avg_o), .split_gain_select_o(sel_o), .cap1_code_o(c1),
    .cap2_code_o(c2), .res1_code_o(r1), .res2_code_o(r2), .res1_kohm_o(k1), .res2_kohm_o(k2),
    .cap1_tenth_pf_o(t1), .cap2_tenth_pf_o(t2));
  always #50 clk_sys_i = ~clk_sys_i;
  function automatic logic [23:0] nx(input logic [23:0] v);
    return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
  endfunction
  task automatic chk(input logic [23:0] sn, input logic [23:0] ex);
    comparisons++;
    if (sn !== ex) begin
      n_fail++;
      $display("mismatch %0t seen %h expected %h", $time, sn, ex);
    end
  endtask
  // idle edge first: back-to-back calls never drop and raise a strobe at once
  task automatic wr(input logic [7:0] ar, input logic [23:0] d);
    @(negedge clk_sys_i);
    addr_i = ar;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge clk_sys_i) wr_en_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ar, input logic [23:0] ex);
    @(negedge clk_sys_i);
    addr_i = ar;
    rd_en_i = 1'b1;
    @(negedge clk_sys_i) rd_en_i = 1'b0;
    chk(rd_o, ex);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    for (i = 0; i < 4; i++) rd(ad[i], 24'h00_0000);
    chk(k1, 24'(kt[0]));
    chk(t2, 24'(ct[0]));
    // random words, masked readback; pulse enable bit reads as zero
    repeat (6) for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      wr(ad[i], lf);
      wr(8'h1f, ~lf);
      rd(8'h1f, 24'h00_0000);
      rd(ad[i], lf & mk[i]);
    end
    for (i = 0; i < 16; i++) begin
      wr(8'h1e, 24'(i));
      chk(avg_o, 24'(i + 1));
      chk(en_o, 24'h00_0000);
    end
    for (i = 0; i < 16; i++) begin
      lf = nx(lf);
      s = i[3];
      a = lf[5:0];
      b = lf[11:6];
      wr(8'h20, {8'h00, s, 9'h000, b});
      wr(8'h21, {18'h0_0000, a});
      @(negedge clk_sys_i);
      chk(sel_o, 24'(s));
      chk({c1, r1}, 24'(a));
      chk({c2, r2}, 24'(s ? b : a));
      chk(k2, 24'(kt[s ? b[2:0] : a[2:0]]));
      chk(t1, 24'(ct[a[5:3]]));
      chk(k1, 24'(kt[a[2:0]]));
      chk(t2, 24'(ct[s ? b[5:3] : a[5:3]]));
    end
    wr(8'h1d, 24'h00_0005);
    wr(8'h1e, 24'h00_0100);
    chk(en_o, 24'h00_0001);
    m = 0;
    repeat (14) begin
      chk(cnt_o, 24'(m));
      chk(wrap_o, 24'(m == 5));
      @(negedge clk_sys_i);
      m = (m == 5) ? 0 : m + 1;
    end
    wr(8'h1e, 24'h00_0000);
    repeat (3) @(negedge clk_sys_i) chk(cnt_o, 24'h00_0000);
    wr(8'h1d, 24'h00_0007);
    wr(8'h1e, 24'h00_0100);
    chk(cnt_o, 24'h00_0000);
    // pulse width is end minus start, whatever the normal source does
    wr(8'h21, 24'h00_0100);
    // the write spans two rising edges since the count restarted at zero
    mc = 2;
    n = 0;
    for (i = 0; i < 26; i++) begin
      lf = nx(lf);
      cr_i = lf[0];
      m = mc;
      @(negedge clk_sys_i);
      mc = (mc == 7) ? 0 : mc + 1;
      chk(cnt_o, 24'(mc));
      chk(cr_o, 24'(m >= ps_i && m < pe_i));
      if (i >= 10) n += (cr_o === 1'b1);
    end
    chk(24'(n), 24'(2 * (pe_i - ps_i)));
    wr(8'h21, 24'h00_0000);
    repeat (20) begin
      lf = nx(lf);
      cr_i = lf[0];
      @(negedge clk_sys_i);
      chk(cr_o, 24'(cr_i));
    end
    close_out();
  end
endmodule
`default_nettype wire
